// ==== mrp_pkg.sv ====
// Shared constants for the memory region protection block: register map,
// field positions, reset values and region geometry.
// Assumes a single 32-bit processor core on the same clock as the block.
package mrp_pkg;

    // ************************************************************
    // Geometry.
    // ************************************************************
    localparam int unsigned MRP_NUM_REGIONS = 8;  // Number of programmable regions.
    localparam int unsigned MRP_IDX_W = 3;  // Width of a region index.
    localparam int unsigned MRP_ADDR_W = 32;  // Address and data width.
    localparam int unsigned MRP_BASE_W = 27;  // Stored base address bits 31:5.

    // ************************************************************
    // Register addresses.
    // ************************************************************
    localparam logic [31:0] MRP_TYPE_ADDR = 32'hE000ED90;  // protection_type_info.
    localparam logic [31:0] MRP_CTRL_ADDR = 32'hE000ED94;  // protection_control.
    localparam logic [31:0] MRP_SEL_ADDR = 32'hE000ED98;  // region_select.
    localparam logic [31:0] MRP_BASE_ADDR = 32'hE000ED9C;  // region_base.
    localparam logic [31:0] MRP_ATTR_ADDR = 32'hE000EDA0;  // region_attr_size.
    localparam logic [31:0] MRP_BASE_A1_ADDR = 32'hE000EDA4;  // region_base_alias1.
    localparam logic [31:0] MRP_ATTR_A1_ADDR = 32'hE000EDA8;  // region_attr_size_alias1.
    localparam logic [31:0] MRP_BASE_A2_ADDR = 32'hE000EDAC;  // region_base_alias2.
    localparam logic [31:0] MRP_ATTR_A2_ADDR = 32'hE000EDB0;  // region_attr_size_alias2.
    localparam logic [31:0] MRP_BASE_A3_ADDR = 32'hE000EDB4;  // region_base_alias3.
    localparam logic [31:0] MRP_ATTR_A3_ADDR = 32'hE000EDB8;  // region_attr_size_alias3.

    // ************************************************************
    // Reset values and field positions.
    // ************************************************************
    localparam logic [31:0] MRP_TYPE_VALUE = 32'h00000800;  // Eight data regions, unified map.
    localparam logic [31:0] MRP_CTRL_RESET = 32'h00000000;  // Control reset value.
    localparam logic [31:0] MRP_SEL_RESET = 32'h00000000;  // Region select reset value.
    localparam logic [31:0] MRP_BASE_RESET = 32'h00000000;  // Base address reset value.
    localparam logic [31:0] MRP_ATTR_RESET = 32'h00000000;  // Attribute/size reset value.
    localparam int unsigned MRP_CTRL_EN_BIT = 0;  // Global protection enable.
    localparam int unsigned MRP_CTRL_HFNMI_BIT = 1;  // fault_handler_protect_enable.
    localparam int unsigned MRP_CTRL_PRIVDEF_BIT = 2;  // priv_background_enable.
    localparam int unsigned MRP_BASE_VALID_BIT = 4;  // Index-update bit of region_base.
    localparam int unsigned MRP_BASE_ADDR_LSB = 5;  // Lowest stored base address bit.
    localparam int unsigned MRP_ATTR_EN_BIT = 0;  // Region enable.
    localparam int unsigned MRP_ATTR_SIZE_LSB = 1;  // Size code, five bits.
    localparam int unsigned MRP_ATTR_SRD_LSB = 8;  // subregion_disable_mask, eight bits.
    localparam int unsigned MRP_ATTR_XN_BIT = 28;  // no_execute.
    localparam int unsigned MRP_ATTR_HI_LSB = 16;  // Attribute halfword.
    localparam logic [31:0] MRP_ATTR_WMASK = 32'h173FFF3F;  // Writable attribute/size bits.

    // ************************************************************
    // Region sizes and fixed address spaces.
    // ************************************************************
    localparam logic [4:0] MRP_SIZE_MIN = 5'h04;  // Smallest size code, 32 bytes.
    localparam logic [4:0] MRP_SIZE_SUB_MIN = 5'h07;  // Smallest code with subregions, 256 bytes.
    localparam logic [5:0] MRP_SUB_IDX_SHIFT = 6'h03;  // Eight subregions per region.
    localparam logic [19:0] MRP_SCS_PAGE = 20'hE000E;  // System control space, bits 31:12.

endpackage

// ==== mrp_match_if.sv ====
// Carrier between the protection block and one region comparator.
// Assumes the comparator is purely combinational on the same clock.
interface mrp_match_if;
    logic [31:0] addr;  // Address under check.
    logic [26:0] base;  // Region base address bits 31:5.
    logic [4:0] size;  // Region size code.
    logic enable;  // Region enable.
    logic [7:0] subregion_disable_mask;  // Subregion disable mask.
    logic hit;  // Address falls in an enabled part of the region.

    modport cfg (output addr, base, size, enable, subregion_disable_mask, input hit);
    modport match (input addr, base, size, enable, subregion_disable_mask, output hit);
endinterface

// ==== mrp_region_match.sv ====
// One region comparator: decides whether an address lies in an enabled
// part of a region. Assumes the base is aligned to the region size.
module mrp_region_match (
    mrp_match_if.match port  // Region settings in, hit out.
);
    import mrp_pkg::*;

    // ************************************************************
    // Range and subregion test.
    // ************************************************************
    // A size code below the minimum never matches, so a bad code cannot open memory.
    always_comb begin
        logic [5:0] span;
        logic [31:0] diff;
        logic [31:0] sub;
        logic sub_off;
        span = {1'b0, port.size} + 6'h01;
        // A shift by 32 clears everything, so a full-map region ignores its base.
        diff = (port.addr ^ {port.base, 5'h00}) >> span;
        sub = port.addr >> (span - MRP_SUB_IDX_SHIFT);
        // Bit zero of the mask is the lowest subregion, bit seven the highest.
        sub_off = (port.size >= MRP_SIZE_SUB_MIN) && port.subregion_disable_mask[sub[2:0]];
        port.hit = port.enable && (port.size >= MRP_SIZE_MIN) && (diff == 32'h00000000) && !sub_off;
    end
endmodule

// ==== mrp_prio_pick.sv ====
// Priority picker: returns the highest-numbered region that hit.
// Assumes hit flags arrive combinationally from the comparators.
module mrp_prio_pick (
    input wire logic [mrp_pkg::MRP_NUM_REGIONS-1:0] hits_i,  // Per-region hit flags.
    output logic any_o,  // At least one region hit.
    output logic [mrp_pkg::MRP_IDX_W-1:0] idx_o  // Highest hit index.
);
    import mrp_pkg::*;

    // ************************************************************
    // Highest index wins.
    // ************************************************************
    // Later iterations overwrite earlier ones, so the top hit is kept.
    always_comb begin
        any_o = |hits_i;
        idx_o = '0;
        for (int i = 0; i < MRP_NUM_REGIONS; i++) begin
            if (hits_i[i]) begin
                idx_o = MRP_IDX_W'(i);
            end
        end
    end
endmodule

// ==== mrp_memory_region_protection.sv ====
// Memory region protection unit: register bank plus the access checker.
// Assumes the core drives the register port and the access port on mclk_i.
module mrp_memory_region_protection (
    input wire logic mclk_i,  // Core clock.
    input wire logic rstn_i,  // Asynchronous reset, active low.
    input wire logic reg_req_i,  // Register access request.
    input wire logic reg_wr_i,  // High for write.
    input wire logic [mrp_pkg::MRP_ADDR_W-1:0] reg_addr_i,  // Register byte address.
    input wire logic [3:0] reg_be_i,  // Byte enables.
    input wire logic [mrp_pkg::MRP_ADDR_W-1:0] reg_wdata_i,  // Write data.
    output logic [mrp_pkg::MRP_ADDR_W-1:0] reg_rdata_o,  // Read data.
    output logic reg_ack_o,  // Access done pulse.
    input wire logic acc_valid_i,  // Access to check.
    input wire logic [mrp_pkg::MRP_ADDR_W-1:0] acc_addr_i,  // Access address.
    input wire logic acc_fetch_i,  // Instruction fetch.
    input wire logic acc_priv_i,  // Privileged access.
    input wire logic acc_vector_i,  // Vector table read.
    input wire logic acc_high_prio_i,  // Running at priority -1 or -2.
    output logic chk_valid_o,  // Check result pulse.
    output logic chk_fault_o,  // Memory management fault.
    output logic chk_hit_o,  // A region matched.
    output logic chk_background_o,  // Default map used as region -1.
    output logic [mrp_pkg::MRP_IDX_W-1:0] chk_region_o,  // Matching region.
    output logic [15:0] chk_attr_o,  // Attribute halfword of the match.
    output logic chk_strong_order_o  // Strongly ordered access.
);
    import mrp_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    // The whole register bank and result latches live in one record.
    typedef struct packed {
        logic en;  // Global protection enable.
        logic hfnmi;  // fault_handler_protect_enable.
        logic privdef;  // priv_background_enable.
        logic [MRP_IDX_W-1:0] sel;  // region_select.
        logic [MRP_NUM_REGIONS-1:0][MRP_BASE_W-1:0] base;  // Base per region.
        logic [MRP_NUM_REGIONS-1:0][31:0] attr;  // Attribute/size per region.
        logic [31:0] rdata;  // Read data.
        logic ack;  // Access done.
        logic chk_valid;  // Check result valid.
        logic chk_fault;  // Fault.
        logic chk_hit;  // Region match.
        logic chk_bg;  // Background map used.
        logic [MRP_IDX_W-1:0] chk_region;  // Matched index.
        logic [15:0] chk_attr;  // Attributes of the match.
        logic chk_strong;  // Strongly ordered.
    } mrp_state_s;

    mrp_state_s state_ff;  // Registered state.
    mrp_state_s nxt_state;  // Next state.
    logic [MRP_NUM_REGIONS-1:0] hits;  // Per-region hits.
    logic hit_any;  // Some region hit.
    logic [MRP_IDX_W-1:0] hit_idx;  // Highest hit.

    // ************************************************************
    // Region comparators.
    // ************************************************************
    // One comparator per region; all look at the same access address.
    for (genvar g = 0; g < MRP_NUM_REGIONS; g++) begin : g_region
        mrp_match_if mif ();
        assign mif.addr = acc_addr_i;
        assign mif.base = state_ff.base[g];
        assign mif.size = state_ff.attr[g][MRP_ATTR_SIZE_LSB +: 5];
        assign mif.enable = state_ff.attr[g][MRP_ATTR_EN_BIT];
        assign mif.subregion_disable_mask = state_ff.attr[g][MRP_ATTR_SRD_LSB +: 8];
        assign hits[g] = mif.hit;
        mrp_region_match u_match (
            .port (mif.match)
        );
    end

    // Overlaps resolve toward the higher index.
    mrp_prio_pick u_pick (
        .hits_i (hits),
        .any_o (hit_any),
        .idx_o (hit_idx)
    );

    // ************************************************************
    // Next-state logic.
    // ************************************************************
    // Register accesses answer one cycle later; so do access checks.
    always_comb begin
        logic is_base;
        logic is_attr;
        logic word;
        logic [MRP_IDX_W-1:0] widx;
        logic [31:0] amerge;
        logic scs;
        logic active;
        nxt_state = state_ff;
        nxt_state.ack = 1'b0;
        nxt_state.chk_valid = 1'b0;
        is_base = (reg_addr_i == MRP_BASE_ADDR) || (reg_addr_i == MRP_BASE_A1_ADDR) ||
                  (reg_addr_i == MRP_BASE_A2_ADDR) || (reg_addr_i == MRP_BASE_A3_ADDR);
        is_attr = (reg_addr_i == MRP_ATTR_ADDR) || (reg_addr_i == MRP_ATTR_A1_ADDR) ||
                  (reg_addr_i == MRP_ATTR_A2_ADDR) || (reg_addr_i == MRP_ATTR_A3_ADDR);
        // Word-only registers ignore partial writes rather than guess lanes.
        word = (reg_be_i == 4'hF);
        widx = state_ff.sel;
        amerge = state_ff.attr[state_ff.sel];
        for (int b = 0; b < 4; b++) begin
            if (reg_be_i[b]) begin
                amerge[8 * b +: 8] = reg_wdata_i[8 * b +: 8];
            end
        end
        amerge = amerge & MRP_ATTR_WMASK;
        // Top-priority handlers run unchecked unless the handler enable is set.
        scs = (acc_addr_i[31:12] == MRP_SCS_PAGE);
        active = state_ff.en && !(acc_high_prio_i && !state_ff.hfnmi);

        // Register port: writes update the bank, reads latch the value.
        if (reg_req_i) begin
            nxt_state.ack = 1'b1;
            nxt_state.rdata = 32'h00000000;
            if (reg_wr_i) begin
                if (reg_addr_i == MRP_CTRL_ADDR && word) begin
                    nxt_state.en = reg_wdata_i[MRP_CTRL_EN_BIT];
                    nxt_state.hfnmi = reg_wdata_i[MRP_CTRL_HFNMI_BIT];
                    nxt_state.privdef = reg_wdata_i[MRP_CTRL_PRIVDEF_BIT];
                end else if (reg_addr_i == MRP_SEL_ADDR && word) begin
                    nxt_state.sel = reg_wdata_i[MRP_IDX_W-1:0];
                end else if (is_base && word) begin
                    // The index bit retargets both select and the base write.
                    if (reg_wdata_i[MRP_BASE_VALID_BIT]) begin
                        widx = reg_wdata_i[MRP_IDX_W-1:0];
                    end
                    nxt_state.sel = widx;
                    nxt_state.base[widx] = reg_wdata_i[31:MRP_BASE_ADDR_LSB];
                end else if (is_attr) begin
                    // Byte and halfword lanes merge into the stored word.
                    nxt_state.attr[state_ff.sel] = amerge;
                end else begin
                    // Read-only, unmapped, or partial write to a word-only register: the write is dropped.
                    nxt_state.rdata = 32'h00000000;
                end
            end else begin
                if (reg_addr_i == MRP_TYPE_ADDR) begin
                    nxt_state.rdata = MRP_TYPE_VALUE;
                end else if (reg_addr_i == MRP_CTRL_ADDR) begin
                    nxt_state.rdata[MRP_CTRL_EN_BIT] = state_ff.en;
                    nxt_state.rdata[MRP_CTRL_HFNMI_BIT] = state_ff.hfnmi;
                    nxt_state.rdata[MRP_CTRL_PRIVDEF_BIT] = state_ff.privdef;
                end else if (reg_addr_i == MRP_SEL_ADDR) begin
                    nxt_state.rdata[MRP_IDX_W-1:0] = state_ff.sel;
                end else if (is_base) begin
                    // The index bit reads as zero; low bits show the select.
                    nxt_state.rdata[31:MRP_BASE_ADDR_LSB] = state_ff.base[state_ff.sel];
                    nxt_state.rdata[MRP_IDX_W-1:0] = state_ff.sel;
                end else if (is_attr) begin
                    nxt_state.rdata = state_ff.attr[state_ff.sel];
                end else begin
                    // Unmapped addresses read as zero.
                    nxt_state.rdata = 32'h00000000;
                end
            end
        end

        // ************************************************************
        // Access check.
        // ************************************************************
        if (acc_valid_i) begin
            nxt_state.chk_valid = 1'b1;
            nxt_state.chk_hit = 1'b0;
            nxt_state.chk_bg = 1'b0;
            nxt_state.chk_region = '0;
            nxt_state.chk_attr = 16'h0000;
            // The system space is never executable and always strongly ordered.
            nxt_state.chk_strong = scs;
            nxt_state.chk_fault = acc_fetch_i && scs;
            if (!active) begin
                // Default map for everyone; the background bit plays no part.
                nxt_state.chk_bg = 1'b1;
            end else if (scs || acc_vector_i) begin
                // Permitted without consulting any region, except system-space fetches, which fault.
                nxt_state.chk_bg = 1'b1;
            end else if (hit_any) begin
                nxt_state.chk_hit = 1'b1;
                nxt_state.chk_region = hit_idx;
                nxt_state.chk_attr = state_ff.attr[hit_idx][31:MRP_ATTR_HI_LSB];
                nxt_state.chk_fault = acc_fetch_i && state_ff.attr[hit_idx][MRP_ATTR_XN_BIT];
            end else if (acc_priv_i && state_ff.privdef) begin
                // Regions outrank the background, which acts as region -1.
                nxt_state.chk_bg = 1'b1;
            end else begin
                // Unprivileged misses and misses without background fault.
                nxt_state.chk_fault = 1'b1;
            end
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    // Reset clears every register; the type value is a constant, not stored.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= '0;
            state_ff.en <= MRP_CTRL_RESET[MRP_CTRL_EN_BIT];
            state_ff.hfnmi <= MRP_CTRL_RESET[MRP_CTRL_HFNMI_BIT];
            state_ff.privdef <= MRP_CTRL_RESET[MRP_CTRL_PRIVDEF_BIT];
            state_ff.sel <= MRP_SEL_RESET[MRP_IDX_W-1:0];
            state_ff.base <= {MRP_NUM_REGIONS{MRP_BASE_RESET[31:MRP_BASE_ADDR_LSB]}};
            state_ff.attr <= {MRP_NUM_REGIONS{MRP_ATTR_RESET}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Outputs, all straight from flip-flops.
    // ************************************************************
    assign reg_rdata_o = state_ff.rdata;
    assign reg_ack_o = state_ff.ack;
    assign chk_valid_o = state_ff.chk_valid;
    assign chk_fault_o = state_ff.chk_fault;
    assign chk_hit_o = state_ff.chk_hit;
    assign chk_background_o = state_ff.chk_bg;
    assign chk_region_o = state_ff.chk_region;
    assign chk_attr_o = state_ff.chk_attr;
    assign chk_strong_order_o = state_ff.chk_strong;
endmodule

// ==== mrp_monitor.sv ====
// Port checker for the protection block: register reads and check results.
// Assumes one core clock and the active-low asynchronous reset.
module mrp_monitor
    import mrp_pkg::*;
(
    input wire logic mclk_i,  // Core clock.
    input wire logic rstn_i,  // Reset, active low.
    input wire logic reg_req_i,  // Register request.
    input wire logic reg_wr_i,  // Write select.
    input wire logic [31:0] reg_addr_i,  // Register address.
    input wire logic [31:0] reg_rdata_o,  // Read data.
    input wire logic acc_valid_i,  // Access to check.
    input wire logic [31:0] acc_addr_i,  // Access address.
    input wire logic acc_fetch_i,  // Fetch.
    input wire logic chk_valid_o,  // Result pulse.
    input wire logic chk_fault_o,  // Fault.
    input wire logic chk_hit_o,  // Region hit.
    input wire logic chk_background_o,  // Default map used.
    input wire logic [2:0] chk_region_o,  // Region index.
    input wire logic [15:0] chk_attr_o,  // Attribute halfword.
    input wire logic chk_strong_order_o  // Strongly ordered.
);
    // ****************************************
    // Shared terms; one clock domain serves all.
    // ****************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    wire rd_en = reg_req_i && !reg_wr_i;  // A register read is taken.
    wire scs = acc_addr_i[31:12] == MRP_SCS_PAGE;  // Address in system control space.

    type_value_a: assert property (rd_en && reg_addr_i == MRP_TYPE_ADDR |=> reg_rdata_o == MRP_TYPE_VALUE)
        else $error("type read");
    base_read_a: assert property (rd_en && reg_addr_i == MRP_BASE_ADDR |=> !reg_rdata_o[4])
        else $error("index bit");
    select_range_a: assert property (rd_en && reg_addr_i == MRP_SEL_ADDR |=> reg_rdata_o[31:3] == 29'h0)
        else $error("select wide");
    scs_order_a: assert property (acc_valid_i && scs |=> chk_valid_o && chk_strong_order_o)
        else $error("system order");
    plain_order_a: assert property (acc_valid_i && !scs |=> chk_valid_o && !chk_strong_order_o)
        else $error("plain order");
    scs_fetch_a: assert property (acc_valid_i && scs && acc_fetch_i |=> chk_fault_o)
        else $error("system fetch");
    hit_priority_a: assert property (chk_valid_o && chk_hit_o |-> !chk_background_o)
        else $error("background on hit");
    miss_region_a: assert property (chk_valid_o && !chk_hit_o |-> chk_region_o == 3'h0 && chk_attr_o == 16'h0)
        else $error("miss output");
endmodule

bind mrp_memory_region_protection mrp_monitor i_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_fetch_i(acc_fetch_i),
    .chk_valid_o(chk_valid_o), .chk_fault_o(chk_fault_o), .chk_hit_o(chk_hit_o), .chk_attr_o(chk_attr_o),
    .chk_background_o(chk_background_o), .chk_region_o(chk_region_o), .chk_strong_order_o(chk_strong_order_o)
);

// ==== mrp_core_model.sv ====
// Core model: issues register accesses and access checks at the falling edge.
// Assumes the bench owns the clock and calls one task at a time.
module mrp_core_model (
    input wire logic mclk_i,  // Core clock.
    output logic reg_req_o,  // Register request.
    output logic reg_wr_o,  // Write select.
    output logic [31:0] reg_addr_o,  // Register address.
    output logic [3:0] reg_be_o,  // Byte lanes.
    output logic [31:0] reg_wdata_o,  // Write data.
    input wire logic [31:0] reg_rdata_i,  // Read data.
    input wire logic reg_ack_i,  // Access done.
    output logic acc_valid_o,  // Access to check.
    output logic [31:0] acc_addr_o,  // Access address.
    output logic acc_fetch_o,  // Fetch.
    output logic acc_priv_o,  // Privileged.
    output logic acc_vector_o,  // Vector read.
    output logic acc_high_prio_o,  // Top-priority handler.
    input wire logic chk_valid_i,  // Result pulse.
    input wire logic chk_fault_i,  // Fault.
    input wire logic chk_hit_i,  // Region hit.
    input wire logic chk_background_i,  // Default map used.
    input wire logic [2:0] chk_region_i,  // Region index.
    input wire logic chk_strong_order_i  // Strongly ordered.
);
    // Everything idle at time zero.
    initial begin
        {reg_req_o, reg_wr_o, reg_addr_o, reg_be_o, reg_wdata_o} = 70'h0;
        {acc_valid_o, acc_addr_o, acc_fetch_o, acc_priv_o, acc_vector_o, acc_high_prio_o} = 37'h0;
    end

    // One register access; callers offer only aligned lanes.
    task automatic reg_access(input logic w, logic [31:0] a, logic [3:0] b, logic [31:0] d, output logic [32:0] res);
        @(negedge mclk_i);
        {reg_req_o, reg_wr_o, reg_addr_o, reg_be_o, reg_wdata_o} = {1'h1, w, a, b, d};
        @(negedge mclk_i);
        res = {reg_ack_i, reg_rdata_i};
        // Released lines show their inverse, so a stale value never passes.
        {reg_req_o, reg_addr_o, reg_be_o, reg_wdata_o} = {1'h0, ~a, ~b, ~d};
    endtask

    // One access check; kind is {fetch, privileged, vector, high priority}.
    task automatic check_access(input logic [31:0] a, logic [3:0] kind, output logic [7:0] res);
        @(negedge mclk_i);
        {acc_valid_o, acc_addr_o, acc_fetch_o, acc_priv_o, acc_vector_o, acc_high_prio_o} = {1'h1, a, kind};
        @(negedge mclk_i);
        res = {chk_valid_i, chk_fault_i, chk_hit_i, chk_background_i, chk_strong_order_i, chk_region_i};
        {acc_valid_o, acc_addr_o, acc_fetch_o, acc_priv_o, acc_vector_o, acc_high_prio_o} = {1'h0, ~a, ~kind};
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the protection block: register bank, then checks.
// Assumes the core model drives all inputs at the falling edge.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mrp_pkg::*;
    localparam logic [3:0] UNP = 4'h0;  // Unprivileged data.
    localparam logic [3:0] PRV = 4'h4;  // Privileged data.
    localparam logic [3:0] FET = 4'h8;  // Unprivileged fetch.
    localparam logic [3:0] VEC = 4'h2;  // Vector read.
    localparam logic [3:0] HPR = 4'h1;  // Priority -1 or -2 handler.
    logic mclk_i, rstn_i, req, wen, ack, av, fet, prv, vec, hp, cv, cf, ch, cbg, cs;
    logic [31:0] addr, wd, rdat, aa;
    logic [3:0] be;
    logic [2:0] creg;
    int fail_count = 0;
    int samples_checked = 0;

    mrp_memory_region_protection i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_wr_i(wen), .reg_addr_i(addr), .reg_be_i(be),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack), .acc_valid_i(av), .acc_addr_i(aa),
        .acc_fetch_i(fet), .acc_priv_i(prv), .acc_vector_i(vec), .acc_high_prio_i(hp), .chk_valid_o(cv),
        .chk_fault_o(cf), .chk_hit_o(ch), .chk_background_o(cbg), .chk_region_o(creg), .chk_attr_o(),
        .chk_strong_order_o(cs));
    mrp_core_model i_core (
        .mclk_i(mclk_i), .reg_req_o(req), .reg_wr_o(wen), .reg_addr_o(addr), .reg_be_o(be), .reg_wdata_o(wd),
        .reg_rdata_i(rdat), .reg_ack_i(ack), .acc_valid_o(av), .acc_addr_o(aa), .acc_fetch_o(fet),
        .acc_priv_o(prv), .acc_vector_o(vec), .acc_high_prio_o(hp), .chk_valid_i(cv), .chk_fault_i(cf),
        .chk_hit_i(ch), .chk_background_i(cbg), .chk_region_i(creg), .chk_strong_order_i(cs));

    // 25 MHz core clock.
    initial begin
        mclk_i = 1'h0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        $display("mismatches %0d of %0d comparisons", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare one acked register answer.
    task automatic cmp_reg(input logic [32:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== {1'h1, exp}) begin
            fail_count++;
            $display("wrong value at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask

    // Compare one check result {valid, fault, hit, background, strong, region}.
    task automatic cmp_chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: check %b, expected %b", $time, got, exp);
        end
    endtask

    // Writes answer with zero data.
    task automatic wr(input logic [31:0] a, d, logic [3:0] b = 4'hF);
        logic [32:0] rr;
        i_core.reg_access(1'h1, a, b, d, rr);
        cmp_reg(rr, 32'h0);
    endtask

    task automatic rd(input logic [31:0] a, exp);
        logic [32:0] rr;
        i_core.reg_access(1'h0, a, 4'hF, 32'h0, rr);
        cmp_reg(rr, exp);
    endtask

    task automatic ck(input logic [31:0] a, logic [3:0] kind, logic [7:0] exp);
        logic [7:0] cr;
        i_core.check_access(a, kind, cr);
        cmp_chk(cr, exp);
    endtask

    // A hang counts as a mismatch and closes the run.
    initial begin
        #200000;
        fail_count++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end

    initial begin
        rstn_i = 1'h0;
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        rstn_i = 1'h1;
        for (int i = 0; i < 11; i++) begin
            rd(MRP_TYPE_ADDR + 32'(4 * i), (i == 0) ? MRP_TYPE_VALUE : 32'h0);
        end
        wr(MRP_TYPE_ADDR, 32'hFFFFFFFF);
        rd(MRP_TYPE_ADDR, MRP_TYPE_VALUE);
        rd(32'hE000EDBC, 32'h0);
        wr(MRP_SEL_ADDR, 32'h7);
        rd(MRP_SEL_ADDR, 32'h7);
        wr(MRP_BASE_ADDR, 32'h20000015);
        rd(MRP_SEL_ADDR, 32'h5);
        rd(MRP_BASE_ADDR, 32'h20000005);
        wr(MRP_SEL_ADDR, 32'h3, 4'h1);
        rd(MRP_SEL_ADDR, 32'h5);
        // Region 0 is 1 KB at an aligned base, region 1 overlaps it with subregions off.
        wr(MRP_BASE_A1_ADDR, 32'h20000010);
        wr(MRP_ATTR_ADDR, 32'h00000013, 4'h3);
        wr(MRP_ATTR_ADDR, 32'h10000000, 4'hC);
        rd(MRP_ATTR_A2_ADDR, 32'h10000013);
        wr(MRP_BASE_ADDR, 32'h20000011);
        wr(MRP_ATTR_ADDR, 32'h00008113);
        wr(MRP_CTRL_ADDR, 32'h1);
        ck(32'h20000000, UNP, 8'hA0);
        ck(32'h20000380, UNP, 8'hA0);
        ck(32'h20000080, UNP, 8'hA1);
        ck(32'h200003FC, UNP, 8'hA0);
        ck(32'h20000400, UNP, 8'hC0);
        ck(32'h20000400, PRV, 8'hC0);
        ck(32'h20000000, FET, 8'hE0);
        ck(32'hE000ED00, UNP, 8'h98);
        ck(32'hE000E000, FET, 8'hD8);
        ck(32'h00000000, VEC, 8'h90);
        ck(32'h20000400, HPR, 8'h90);
        wr(MRP_CTRL_ADDR, 32'h7);
        ck(32'h20000400, HPR, 8'hC0);
        ck(32'h20000400, PRV, 8'h90);
        ck(32'h20000080, PRV, 8'hA1);
        // Stale regions are switched off before the next layout.
        wr(MRP_ATTR_ADDR, 32'h0);
        wr(MRP_SEL_ADDR, 32'h0);
        wr(MRP_ATTR_ADDR, 32'h0, 4'h1);
        wr(MRP_CTRL_ADDR, 32'h5);
        ck(32'h20000000, PRV, 8'h90);
        ck(32'h20000000, UNP, 8'hC0);
        wr(MRP_CTRL_ADDR, 32'h4);
        ck(32'h20000400, UNP, 8'h90);
        wr(MRP_BASE_ADDR, 32'h40000017);
        wr(MRP_ATTR_ADDR, 32'h0000003F);
        wr(MRP_CTRL_ADDR, 32'h1);
        ck(32'h00001000, UNP, 8'hA7);
        ck(32'hFFFFF000, UNP, 8'hA7);
        stop_test();
    end
endmodule
